// File: umsd_char_match.sv
// Receive-side comparison of characters against the flow and special characters.
// Assumes one received character per rx_valid pulse on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module umsd_char_match
	import umsd_pkg::*;
(
	input  wire logic    ref_clk,
	input  wire logic    nrst,
	umsd_match_if.matcher m
);
	logic [1:0] rx_sel;
	logic [1:0] tx_sel;
	logic       is_res1, is_res2, is_pau1, is_pau2;
	logic       seq_mode, any_mode;
	logic       res1_seen_q, pau1_seen_q;

	assign rx_sel  = m.enhanced_feature[EFR_RX_LO +: 2];
	assign tx_sel  = m.enhanced_feature[EFR_TX_LO +: 2];
	assign is_res1 = m.rx_char == m.res1;
	assign is_res2 = m.rx_char == m.res2;
	assign is_pau1 = m.rx_char == m.pau1;
	// Bit 0 of the pause character lines up with the received LSB
	assign is_pau2 = m.rx_char == m.pau2;

	// Either character of a pair, or the two-character sequence
	assign any_mode = rx_sel == FLOW_BOTH && (tx_sel == FLOW_SET1 || tx_sel == FLOW_SET2);
	assign seq_mode = rx_sel == FLOW_BOTH && !any_mode;

	// ==========================================
	// Sequence tracking for dual characters
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			res1_seen_q <= 1'b0;
			pau1_seen_q <= 1'b0;
		end else if (m.rx_valid) begin
			res1_seen_q <= is_res1;
			pau1_seen_q <= is_pau1;
		end
	end

	// ==========================================
	// Hit decode
	always_comb begin
		m.resume_hit = 1'b0;
		m.pause_hit  = 1'b0;
		if (m.rx_valid) begin
			if (rx_sel == FLOW_SET1) begin
				m.resume_hit = is_res1;
				m.pause_hit  = is_pau1;
			end else if (rx_sel == FLOW_SET2) begin
				m.resume_hit = is_res2;
				m.pause_hit  = is_pau2;
			end else if (any_mode) begin
				m.resume_hit = is_res1 || is_res2;
				m.pause_hit  = is_pau1 || is_pau2;
			end else if (seq_mode) begin
				m.resume_hit = res1_seen_q && is_res2;
				m.pause_hit  = pau1_seen_q && is_pau2;
			end
		end
	end

	// Special character check runs beside flow control
	assign m.special_hit = m.rx_valid && m.enhanced_feature[EFR_SPEC_EN] && is_pau2;
	// Second-set pause character is kept out of the FIFO on a special match with receive set 2
	assign m.store = m.rx_valid && !(m.special_hit && rx_sel == FLOW_SET2);
endmodule
`default_nettype wire

// File: umsd_match_if.sv
// Signals between the register block and the receive character matcher.
// Assumes both ends sit on ref_clk.
`timescale 1ns/10ps
`default_nettype none
interface umsd_match_if;
	logic       rx_valid;
	logic [7:0] rx_char;
	logic [7:0] enhanced_feature;
	logic [7:0] res1;
	logic [7:0] res2;
	logic [7:0] pau1;
	logic [7:0] pau2;
	logic       resume_hit;
	logic       pause_hit;
	logic       special_hit;
	logic       store;

	modport regs (output rx_valid, rx_char, enhanced_feature, res1, res2, pau1, pau2,
		input resume_hit, pause_hit, special_hit, store);
	modport matcher (input rx_valid, rx_char, enhanced_feature, res1, res2, pau1, pau2,
		output resume_hit, pause_hit, special_hit, store);
endinterface
`default_nettype wire

// File: umsd_modem_model.sv
// Remote modem model: drives the modem pins and the received characters.
// Assumes the bench calls its tasks; pins change only after a ref_clk edge.
`timescale 1ns/10ps
`default_nettype none
module umsd_modem_model (
	input  wire logic       ref_clk,
	output logic            cts_n,
	output logic            dsr_n,
	output logic            ri_n,
	output logic            cd_n,
	output logic            rx_char_valid,
	output logic [7:0]      rx_char
);
	initial begin
		{cd_n, ri_n, dsr_n, cts_n} = 4'hF;
		rx_char_valid = 1'b0;
		rx_char = 8'h00;
	end

	// ==========================================
	// Pin order is cd, ri, dsr, cts
	task automatic lines(input logic [3:0] v);
		@(posedge ref_clk);
		{cd_n, ri_n, dsr_n, cts_n} <= v;
	endtask

	// Idle data shows the inverse of the last character
	task automatic send(input logic [7:0] c);
		@(posedge ref_clk);
		rx_char_valid <= 1'b1;
		rx_char <= c;
		@(posedge ref_clk);
		rx_char_valid <= 1'b0;
		rx_char <= ~c;
	endtask
endmodule
`default_nettype wire

// File: umsd_pkg.sv
// Constants, register map and types for the UART modem status, divisor and flow block.
// Assumes one 125 MHz clock domain and an Avalon-MM slave with byte addresses.
package umsd_pkg;

	// ==========================================
	// Register byte offsets
	localparam logic [5:0] OFS_MODEM_STATUS  = 6'h00;
	localparam logic [5:0] OFS_SCRATCH_PAD   = 6'h04;
	localparam logic [5:0] OFS_DIVISOR_LOW   = 6'h08;
	localparam logic [5:0] OFS_DIVISOR_HIGH  = 6'h0C;
	localparam logic [5:0] OFS_DIVISOR_FRAC  = 6'h10;
	localparam logic [5:0] OFS_ENH_FEATURE   = 6'h14;
	localparam logic [5:0] OFS_RESUME_CHAR_1 = 6'h18;
	localparam logic [5:0] OFS_RESUME_CHAR_2 = 6'h1C;
	localparam logic [5:0] OFS_PAUSE_CHAR_1  = 6'h20;
	localparam logic [5:0] OFS_PAUSE_CHAR_2  = 6'h24;
	localparam logic [5:0] OFS_INT_ENABLE    = 6'h28;
	localparam logic [5:0] OFS_MODEM_CONTROL = 6'h2C;
	localparam logic [5:0] OFS_FIFO_CONTROL  = 6'h30;
	localparam logic [5:0] OFS_INT_SOURCE    = 6'h34;

	// ==========================================
	// Reset values
	localparam logic [7:0] RST_SCRATCH_PAD  = 8'hFF;
	localparam logic [7:0] RST_DIVISOR_LOW  = 8'h01;
	localparam logic [7:0] RST_DIVISOR_HIGH = 8'h00;
	localparam logic [7:0] RST_ZERO         = 8'h00;

	// ==========================================
	// Field positions
	localparam int EFR_RX_LO      = 0;
	localparam int EFR_TX_LO      = 2;
	localparam int EFR_ENH_EN     = 4;
	localparam int EFR_SPEC_EN    = 5;
	localparam int EFR_AUTO_CTS   = 7;
	localparam int MCR_DTR        = 0;
	localparam int MCR_RTS        = 1;
	localparam int MCR_OP1        = 2;
	localparam int MCR_OP2        = 3;
	localparam int MCR_LOOP       = 4;
	localparam int IER_MODEM      = 3;
	localparam int IER_FLOW       = 5;
	localparam int ISR_SPECIAL    = 4;
	localparam int ISR_PAUSE      = 5;
	localparam int FRAC_RATE_LO   = 4;

	// Write masks of the bits that need the enhanced enable
	localparam logic [7:0] GATE_IER = 8'hF0;
	localparam logic [7:0] GATE_FCR = 8'h30;
	localparam logic [7:0] GATE_MCR = 8'hE0;

	// Flow control selections, two bits each
	localparam logic [1:0] FLOW_NONE  = 2'h0;
	localparam logic [1:0] FLOW_SET2  = 2'h1;
	localparam logic [1:0] FLOW_SET1  = 2'h2;
	localparam logic [1:0] FLOW_BOTH  = 2'h3;

	typedef enum logic [1:0] {
		RATE_16X = 2'h0,
		RATE_8X  = 2'h1,
		RATE_4X  = 2'h3
	} umsd_rate_t;

endpackage

// File: umsd_top.sv
// UART channel register block: modem status, scratch pad, divisor, flow control.
// Assumes modem pins are asynchronous and the receiver and transmitter share ref_clk.
//
// How it works
// - carrier change sets flag, raises modem interrupt
// - auto CTS halts transmitter after current character
// - CTS status inverts pin, loopback shows RTS
// - DSR status inverts pin, loopback shows DTR
// - RI status inverts pin, loopback shows bit 2
// - CD status inverts pin, loopback shows bit 3
// - scratch pad is read/write, resets to FF
// - divisor is high:low plus fraction sixteenths
// - fraction register reachable only with enhanced enable
// - fraction bits 5:4 select 16X, 8X, 4X
// - dual mode with transmit 11/00 treats character pairs as sequences
// - feature bits 3:2 select transmitted flow characters
// - feature bits 1:0 select receive comparison set
// - receive 11, single transmit pair: either matches
// - receive 11, transmit 11/00: sequence only
// - enhanced bits writable only while enable set
// - reset clears enhanced bits and fraction
// - special detect compares with pause character 2
// - pause character bit 0 aligns with LSB
// - receive 10 with special detect: both independent
// - receive 01 special match skips FIFO, interrupts
`timescale 1ns/10ps
`default_nettype none
module umsd_top
	import umsd_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Modem pins, active low
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	input  wire logic        ri_n,
	input  wire logic        cd_n,
	output logic             dtr_n,
	output logic             rts_n,
	// Receiver side
	input  wire logic        rx_char_valid,
	input  wire logic [7:0]  rx_char,
	output logic             rx_push_valid,
	output logic [7:0]       rx_push_data,
	output logic             resume_detect,
	output logic             pause_detect,
	// Transmitter side
	input  wire logic        tx_char_busy,
	output logic             tx_halt,
	output logic [1:0]       tx_flow_sel,
	// Baud generator
	output logic [15:0]      divisor_int,
	output logic [3:0]       divisor_frac,
	output umsd_pkg::umsd_rate_t sample_rate,
	output logic             loopback,
	// Interrupt requests
	output logic             modem_irq,
	output logic             flow_irq
);
	import umsd_pkg::*;

	logic [3:0] pin_meta_q, pin_sync_q;
	logic [3:0] stat;
	logic [3:0] stat_prev_q;
	logic       primed_q;
	logic [3:0] delta_q;
	logic [3:0] delta_set;
	logic       ack_q;
	logic [31:0] readdata_q;
	logic [7:0] rd_mux;
	logic       wr_fire, rd_fire, enh;
	logic [7:0] wdata;
	logic [7:0] spr_q, dll_q, dlm_q, frac_q, efr_q;
	logic [7:0] res1_q, res2_q, pau1_q, pau2_q;
	logic [7:0] ier_q, mcr_q, fcr_q, isr_q;
	logic       tx_halt_q;
	logic       push_valid_q;
	logic [7:0] push_data_q;
	logic       resume_q, pause_q;
	logic       dtr_n_q, rts_n_q;

	umsd_match_if mif ();

	// ==========================================
	// Pin synchronisers, idle high
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta_q <= 4'hF;
			pin_sync_q <= 4'hF;
		end else begin
			pin_meta_q <= {cd_n, ri_n, dsr_n, cts_n};
			pin_sync_q <= pin_meta_q;
		end
	end

	// ==========================================
	// Modem status with loopback substitution
	assign loopback = mcr_q[MCR_LOOP];
	always_comb begin
		if (loopback) begin
			stat[0] = mcr_q[MCR_RTS];
			stat[1] = mcr_q[MCR_DTR];
			stat[2] = mcr_q[MCR_OP1];
			stat[3] = mcr_q[MCR_OP2];
		end else begin
			stat = ~pin_sync_q;
		end
	end

	// Ring flag only on the trailing edge of ringing
	assign delta_set[0] = primed_q && (stat[0] != stat_prev_q[0]);
	assign delta_set[1] = primed_q && (stat[1] != stat_prev_q[1]);
	assign delta_set[2] = primed_q && stat_prev_q[2] && !stat[2];
	assign delta_set[3] = primed_q && (stat[3] != stat_prev_q[3]);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stat_prev_q <= 4'h0;
			primed_q    <= 1'b0;
		end else begin
			stat_prev_q <= stat;
			primed_q    <= 1'b1;
		end
	end

	// Flags seen by the read are cleared; a new change wins
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			delta_q <= 4'h0;
		end else if (rd_fire && avs_address == OFS_MODEM_STATUS) begin
			delta_q <= (delta_q & ~readdata_q[3:0]) | delta_set;
		end else begin
			delta_q <= delta_q | delta_set;
		end
	end

	assign modem_irq = ier_q[IER_MODEM] && (|delta_q);

	// ==========================================
	// Avalon-MM handshake, one wait state
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_fire = avs_write && ack_q && avs_byteenable[0];
	assign rd_fire = avs_read && ack_q;
	assign wdata   = avs_writedata[7:0];
	assign enh     = efr_q[EFR_ENH_EN];
	assign avs_readdata = readdata_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	always_comb begin
		if (avs_address == OFS_MODEM_STATUS) begin
			rd_mux = {stat, delta_q};
		end else if (avs_address == OFS_SCRATCH_PAD) begin
			rd_mux = spr_q;
		end else if (avs_address == OFS_DIVISOR_LOW) begin
			rd_mux = dll_q;
		end else if (avs_address == OFS_DIVISOR_HIGH) begin
			rd_mux = dlm_q;
		end else if (avs_address == OFS_DIVISOR_FRAC) begin
			rd_mux = enh ? frac_q : RST_ZERO;
		end else if (avs_address == OFS_ENH_FEATURE) begin
			rd_mux = efr_q;
		end else if (avs_address == OFS_RESUME_CHAR_1) begin
			rd_mux = res1_q;
		end else if (avs_address == OFS_RESUME_CHAR_2) begin
			rd_mux = res2_q;
		end else if (avs_address == OFS_PAUSE_CHAR_1) begin
			rd_mux = pau1_q;
		end else if (avs_address == OFS_PAUSE_CHAR_2) begin
			rd_mux = pau2_q;
		end else if (avs_address == OFS_INT_ENABLE) begin
			rd_mux = ier_q;
		end else if (avs_address == OFS_MODEM_CONTROL) begin
			rd_mux = mcr_q;
		end else if (avs_address == OFS_FIFO_CONTROL) begin
			rd_mux = fcr_q;
		end else if (avs_address == OFS_INT_SOURCE) begin
			rd_mux = isr_q;
		end else begin
			rd_mux = RST_ZERO;
		end
	end

	// Read data captured in the wait cycle, stands in the answer cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			readdata_q <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			readdata_q <= {24'h00_0000, rd_mux};
		end
	end

	// ==========================================
	// Plain registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			spr_q <= RST_SCRATCH_PAD;
		end else if (wr_fire && avs_address == OFS_SCRATCH_PAD) begin
			spr_q <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dll_q <= RST_DIVISOR_LOW;
			dlm_q <= RST_DIVISOR_HIGH;
		end else if (wr_fire && avs_address == OFS_DIVISOR_LOW) begin
			dll_q <= wdata;
		end else if (wr_fire && avs_address == OFS_DIVISOR_HIGH) begin
			dlm_q <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			efr_q  <= RST_ZERO;
			res1_q <= RST_ZERO;
			res2_q <= RST_ZERO;
			pau1_q <= RST_ZERO;
			pau2_q <= RST_ZERO;
		end else if (wr_fire) begin
			if (avs_address == OFS_ENH_FEATURE) begin
				efr_q <= wdata;
			end else if (avs_address == OFS_RESUME_CHAR_1) begin
				res1_q <= wdata;
			end else if (avs_address == OFS_RESUME_CHAR_2) begin
				res2_q <= wdata;
			end else if (avs_address == OFS_PAUSE_CHAR_1) begin
				pau1_q <= wdata;
			end else if (avs_address == OFS_PAUSE_CHAR_2) begin
				pau2_q <= wdata;
			end
		end
	end

	// ==========================================
	// Registers with enhanced bits held while the enable is clear
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			frac_q <= RST_ZERO;
			ier_q  <= RST_ZERO;
			mcr_q  <= RST_ZERO;
			fcr_q  <= RST_ZERO;
		end else if (wr_fire) begin
			if (avs_address == OFS_DIVISOR_FRAC && enh) begin
				frac_q <= wdata;
			end else if (avs_address == OFS_INT_ENABLE) begin
				ier_q <= enh ? wdata : ((ier_q & GATE_IER) | (wdata & ~GATE_IER));
			end else if (avs_address == OFS_MODEM_CONTROL) begin
				mcr_q <= enh ? wdata : ((mcr_q & GATE_MCR) | (wdata & ~GATE_MCR));
			end else if (avs_address == OFS_FIFO_CONTROL) begin
				fcr_q <= enh ? wdata : ((fcr_q & GATE_FCR) | (wdata & ~GATE_FCR));
			end
		end
	end

	// Source bits 4-5: sticky, write one clears when enabled, set wins
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			isr_q <= RST_ZERO;
		end else begin
			if (mif.special_hit) begin
				isr_q[ISR_SPECIAL] <= 1'b1;
			end else if (wr_fire && enh && avs_address == OFS_INT_SOURCE
				&& wdata[ISR_SPECIAL]) begin
				isr_q[ISR_SPECIAL] <= 1'b0;
			end
			if (mif.pause_hit) begin
				isr_q[ISR_PAUSE] <= 1'b1;
			end else if (wr_fire && enh && avs_address == OFS_INT_SOURCE
				&& wdata[ISR_PAUSE]) begin
				isr_q[ISR_PAUSE] <= 1'b0;
			end
		end
	end

	assign flow_irq = ier_q[IER_FLOW] && (isr_q[ISR_SPECIAL] || isr_q[ISR_PAUSE]);

	// ==========================================
	// Divisor and sampling rate
	assign divisor_int  = {dlm_q, dll_q};
	assign divisor_frac = frac_q[3:0];
	always_comb begin
		if (frac_q[FRAC_RATE_LO + 1]) begin
			sample_rate = RATE_4X;
		end else if (frac_q[FRAC_RATE_LO]) begin
			sample_rate = RATE_8X;
		end else begin
			sample_rate = RATE_16X;
		end
	end

	// ==========================================
	// Flow control character handling
	assign tx_flow_sel  = efr_q[EFR_TX_LO +: 2];
	assign mif.rx_valid = rx_char_valid;
	assign mif.rx_char  = rx_char;
	assign mif.enhanced_feature      = efr_q;
	assign mif.res1     = res1_q;
	assign mif.res2     = res2_q;
	assign mif.pau1     = pau1_q;
	assign mif.pau2     = pau2_q;

	umsd_char_match u_match (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.m       (mif.matcher)
	);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			push_valid_q <= 1'b0;
			push_data_q  <= RST_ZERO;
			resume_q     <= 1'b0;
			pause_q      <= 1'b0;
		end else begin
			push_valid_q <= mif.store;
			resume_q     <= mif.resume_hit;
			pause_q      <= mif.pause_hit;
			if (rx_char_valid) begin
				push_data_q <= rx_char;
			end
		end
	end

	assign rx_push_valid = push_valid_q;
	assign rx_push_data  = push_data_q;
	assign resume_detect = resume_q;
	assign pause_detect  = pause_q;

	// ==========================================
	// Auto CTS: stop only between characters
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_halt_q <= 1'b0;
		end else if (!efr_q[EFR_AUTO_CTS] || stat[0]) begin
			tx_halt_q <= 1'b0;
		end else if (!tx_char_busy) begin
			tx_halt_q <= 1'b1;
		end
	end
	assign tx_halt = tx_halt_q;

	// ==========================================
	// Modem outputs, idle high in loopback
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dtr_n_q <= 1'b1;
			rts_n_q <= 1'b1;
		end else begin
			dtr_n_q <= !(mcr_q[MCR_DTR] && !loopback);
			rts_n_q <= !(mcr_q[MCR_RTS] && !loopback);
		end
	end
	assign dtr_n = dtr_n_q;
	assign rts_n = rts_n_q;

endmodule
`default_nettype wire

// File: umsd_top_monitor.sv
// Port checker for umsd_top, bound to every instance.
// Assumes one ref_clk domain and the one wait state bus answer.
`timescale 1ns/10ps
`default_nettype none
module umsd_top_monitor
	import umsd_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic        rx_char_valid,
	input wire logic [7:0]  rx_char,
	input wire logic        rx_push_valid,
	input wire logic [7:0]  rx_push_data,
	input wire logic        resume_detect,
	input wire logic        pause_detect,
	input wire logic        tx_char_busy,
	input wire logic        tx_halt,
	input wire logic [1:0]  tx_flow_sel,
	input wire logic [15:0] divisor_int,
	input wire logic [3:0]  divisor_frac,
	input wire umsd_pkg::umsd_rate_t sample_rate,
	input wire logic        loopback,
	input wire logic        dtr_n,
	input wire logic        rts_n,
	input wire logic        modem_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic acc_w;
	assign acc_w = avs_write && !avs_waitrequest;

	// ==========================================
	// Properties
	property p_one_wait;
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	property p_div_low;
		acc_w && avs_address == OFS_DIVISOR_LOW && avs_byteenable[0]
			|=> divisor_int[7:0] == $past(avs_writedata[7:0]);
	endproperty
	property p_frac_hold;
		!(acc_w && avs_address == OFS_DIVISOR_FRAC) |=> $stable({sample_rate, divisor_frac});
	endproperty
	property p_sel_hold;
		!(acc_w && avs_address == OFS_ENH_FEATURE) |=> $stable(tx_flow_sel);
	endproperty
	property p_loop_pins;
		loopback |=> dtr_n && rts_n;
	endproperty
	property p_push;
		rx_push_valid |-> $past(rx_char_valid) && rx_push_data == $past(rx_char);
	endproperty
	property p_detect;
		pause_detect || resume_detect |-> $past(rx_char_valid);
	endproperty
	property p_irq_clear;
		$fell(modem_irq) |-> $past(acc_w)
			|| $past(avs_read && !avs_waitrequest && avs_address == OFS_MODEM_STATUS);
	endproperty
	property p_halt;
		$rose(tx_halt) |-> !$past(tx_char_busy);
	endproperty

	// ==========================================
	// Assertions
	a_one_wait: assert property (p_one_wait)
		else $error("bus answer not after one wait state");
	a_div_low: assert property (p_div_low)
		else $error("divisor low byte not taken");
	a_frac_hold: assert property (p_frac_hold)
		else $error("fraction changed without a write");
	a_sel_hold: assert property (p_sel_hold)
		else $error("flow select changed without a write");
	a_loop_pins: assert property (p_loop_pins)
		else $error("modem outputs active in loopback");
	a_push: assert property (p_push)
		else $error("push not one cycle after character");
	a_detect: assert property (p_detect)
		else $error("flow detect without a character");
	a_irq_clear: assert property (p_irq_clear)
		else $error("modem interrupt dropped without access");
	a_halt: assert property (p_halt)
		else $error("halt raised mid character");

	c_pause: cover property (pause_detect);
	c_halt: cover property ($rose(tx_halt));
	c_irq: cover property ($fell(modem_irq));
endmodule
bind umsd_top umsd_top_monitor u_umsd_top_monitor (.*);
`default_nettype wire

// File: umsd_top_tb.sv
// Self-checking bench for umsd_top with the remote modem model.
// Assumes the monitor is bound in and the package register map.
`timescale 1ns/10ps
`default_nettype none
module umsd_top_tb;
	import umsd_pkg::*;
	localparam umsd_rate_t RT [4] = '{RATE_16X, RATE_8X, RATE_4X, RATE_4X};
	logic        ref_clk, nrst, avs_read, avs_write, avs_waitrequest, tx_char_busy;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdat;
	logic [3:0]  avs_byteenable, divisor_frac;
	logic        cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, rx_char_valid, rx_push_valid;
	logic [7:0]  rx_char, rx_push_data;
	logic        resume_detect, pause_detect, tx_halt, loopback, modem_irq, flow_irq;
	logic [1:0]  tx_flow_sel;
	logic [15:0] divisor_int;
	umsd_rate_t  sample_rate;
	int          error_cnt = 0, compares = 0, cyc = 0;

	umsd_top u_umsd_top (.*);
	umsd_modem_model u_umsd_modem_model (.ref_clk(ref_clk), .cts_n(cts_n), .dsr_n(dsr_n),
		.ri_n(ri_n), .cd_n(cd_n), .rx_char_valid(rx_char_valid), .rx_char(rx_char));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ==========================================
	// Common tasks
	task automatic conclude();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic req(input logic rw, input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !rw;
		avs_write <= rw;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		req(1'b1, a, d);
	endtask

	task automatic rc(input logic [5:0] a, input logic [7:0] e);
		req(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), rdat, {24'h0, e});
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	// Flow selection bits cleared before a new setting
	task automatic sel(input logic [7:0] v);
		wr(OFS_ENH_FEATURE, v & 8'hF0);
		wr(OFS_ENH_FEATURE, v);
	endtask

	task automatic rx(input logic [7:0] c, input logic [2:0] e);
		u_umsd_modem_model.send(c);
		@(negedge ref_clk);
		chk("push pause resume", {rx_push_valid, pause_detect, resume_detect}, e);
		if (e[2]) chk("push data", rx_push_data, c);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk("divisor", divisor_int, 16'h0001);
		chk("frac sel", {divisor_frac, sample_rate, tx_flow_sel}, {4'h0, RATE_16X, 2'h0});
		chk("pins", {dtr_n, rts_n, tx_halt}, 3'b110);
		rc(OFS_SCRATCH_PAD, 8'hFF);
		rc(OFS_ENH_FEATURE, 8'h00);
		rc(OFS_INT_ENABLE, 8'h00);
		rc(OFS_MODEM_CONTROL, 8'h00);
		rc(OFS_MODEM_STATUS, 8'h00);
	endtask

	task automatic t_regs();
		wr(OFS_SCRATCH_PAD, 8'h5A);
		rc(OFS_SCRATCH_PAD, 8'h5A);
		@(posedge ref_clk);
		avs_byteenable <= 4'h0;
		wr(OFS_SCRATCH_PAD, 8'h00);
		@(posedge ref_clk);
		avs_byteenable <= 4'hF;
		rc(OFS_SCRATCH_PAD, 8'h5A);
		rc(6'h38, 8'h00);
		wr(OFS_DIVISOR_FRAC, 8'h35);
		rc(OFS_DIVISOR_FRAC, 8'h00);
		wr(OFS_DIVISOR_LOW, 8'h34);
		wr(OFS_DIVISOR_HIGH, 8'h12);
		chk("divisor", divisor_int, 16'h1234);
		wr(OFS_ENH_FEATURE, 8'h10);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DIVISOR_FRAC, {2'h0, i[1:0], 4'h9});
			chk("rate", sample_rate, RT[i]);
		end
		chk("frac", divisor_frac, 4'h9);
		wr(OFS_MODEM_CONTROL, 8'hE0);
		wr(OFS_ENH_FEATURE, 8'h00);
		wr(OFS_MODEM_CONTROL, 8'h00);
		wr(OFS_DIVISOR_FRAC, 8'h05);
		rc(OFS_MODEM_CONTROL, 8'hE0);
		chk("frac rate", {divisor_frac, sample_rate}, {4'h9, RATE_4X});
		wr(OFS_ENH_FEATURE, 8'h10);
		rc(OFS_DIVISOR_FRAC, 8'h39);
	endtask

	task automatic t_modem();
		wr(OFS_MODEM_CONTROL, 8'h1F);
		w(5);
		chk("loop pins", {loopback, dtr_n, rts_n}, 3'b111);
		rc(OFS_MODEM_STATUS, 8'hFB);
		rc(OFS_MODEM_STATUS, 8'hF0);
		wr(OFS_MODEM_CONTROL, 8'h12);
		w(5);
		rc(OFS_MODEM_STATUS, 8'h1E);
		u_umsd_modem_model.lines(4'hA);
		w(5);
		wr(OFS_MODEM_CONTROL, 8'h03);
		w(5);
		chk("pins", {dtr_n, rts_n}, 2'b00);
		rc(OFS_MODEM_STATUS, 8'h50);
		wr(OFS_INT_ENABLE, 8'h08);
		chk("modem irq", modem_irq, 1'b0);
		u_umsd_modem_model.lines(4'h2);
		w(5);
		chk("modem irq", modem_irq, 1'b1);
		rc(OFS_MODEM_STATUS, 8'hD8);
		chk("modem irq", modem_irq, 1'b0);
	endtask

	task automatic t_flow();
		wr(OFS_RESUME_CHAR_1, 8'h11);
		wr(OFS_RESUME_CHAR_2, 8'h91);
		wr(OFS_PAUSE_CHAR_1, 8'h13);
		wr(OFS_PAUSE_CHAR_2, 8'h93);
		for (int k = 0; k < 4; k++) begin
			sel({4'h1, k[1:0], 2'h0});
			chk("tx sel", tx_flow_sel, k[1:0]);
		end
		sel(8'h12);
		rx(8'h13, 3'b110);
		rx(8'h11, 3'b101);
		rx(8'h93, 3'b100);
		sel(8'h11);
		rx(8'h93, 3'b110);
		rx(8'h11, 3'b100);
		sel(8'h1B);
		rx(8'h93, 3'b110);
		rx(8'h11, 3'b101);
		sel(8'h13);
		rx(8'h93, 3'b100);
		rx(8'h13, 3'b100);
		rx(8'h93, 3'b110);
	endtask

	task automatic t_special();
		sel(8'h32);
		rx(8'h93, 3'b100);
		rx(8'h13, 3'b110);
		rc(OFS_INT_SOURCE, 8'h30);
		wr(OFS_INT_SOURCE, 8'h30);
		rx(8'hC9, 3'b100);
		rc(OFS_INT_SOURCE, 8'h00);
		wr(OFS_INT_ENABLE, 8'h20);
		sel(8'h31);
		rx(8'h93, 3'b010);
		chk("flow irq", flow_irq, 1'b1);
		rc(OFS_INT_SOURCE, 8'h30);
	endtask

	task automatic t_cts();
		sel(8'h90);
		@(posedge ref_clk);
		tx_char_busy <= 1'b1;
		u_umsd_modem_model.lines(4'h3);
		w(6);
		chk("halt", tx_halt, 1'b0);
		@(posedge ref_clk);
		tx_char_busy <= 1'b0;
		w(2);
		chk("halt", tx_halt, 1'b1);
		u_umsd_modem_model.lines(4'h2);
		w(6);
		chk("halt", tx_halt, 1'b0);
	endtask

	// ==========================================
	// Main sequence and hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		nrst = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		tx_char_busy = 1'b0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		@(negedge ref_clk);
		t_reset();
		t_regs();
		t_modem();
		t_flow();
		t_special();
		t_cts();
		conclude();
	end
endmodule
`default_nettype wire
